/* File: logic/twm_master.sv */
// Two-wire bus master: write transfers, idle flag, disable and alert input
`timescale 1ns/1ps
// Operation
// RULE1 - A NAK with bytes still to send raises the idle flag at once, before the STOP goes out.
// RULE2 - A one written to the master-disable bit turns the master off.
// RULE3 - Turning the master off releases clock and data lines high at once, cutting any STOP short.
// RULE4 - Software should keep the master on, or wait two serial clock periods after idle before disabling it.
// RULE5 - The SMBus alert input is active high, so an active-low alert line needs an inverter outside.
// RULE6 - When master and slave units share pins the alert input must not be used.
// RULE7 - After a NAK with bytes remaining the master still ends the transfer with a STOP while enabled.
module twm_master import twm_pkg::*; (
   // System clock domain
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   // Link clock domain, drives the serial engine
   input  wire logic       link_clk_in,
   // Master enable and disable strobes
   input  wire logic       master_enable_in,
   input  wire logic       master_disable_bit_in,
   output logic            master_enabled_out,
   // Transfer command
   input  wire logic       cmd_start_in,
   input  wire logic [6:0] cmd_addr_in,
   input  wire logic [7:0] cmd_count_in,
   output logic            cmd_ready_out,
   output logic            idle_status_flag_out,
   // Data bytes to send
   input  wire logic       byte_valid_in,
   input  wire logic [7:0] byte_data_in,
   output logic            byte_ready_out,
   // Serial clock line, open drain
   input  wire logic       serial_clock_line_in,
   output logic            serial_clock_line_out,
   output logic            serial_clock_line_oe_out,
   // Serial data line, open drain
   input  wire logic       serial_data_line_in,
   output logic            serial_data_line_out,
   output logic            serial_data_line_oe_out,
   // SMBus alert
   input  wire logic       smbus_alert_input_in,
   output logic            alert_out
);
   // System domain state
   logic       start_tog_q, ack_tog_q, need_seen_q, idle_d1_q;
   logic [6:0] addr_q;
   logic [7:0] count_q, hold_q;
   logic       idle_s, busy_s, need_s, alert_s, scl_pin_s;
   // Link domain state
   logic       lrst_b, dis_s, start_s, ack_s, sda_s;
   logic       start_seen_q, ack_seen_q, need_tog_q, idle_q, ack_kind_q;
   logic       scl_oe_q, sda_oe_q;
   logic [2:0] ph_q, bit_q;
   logic [7:0] shift_q, cnt_q, cnt_m1;
   twm_state_e state_q;

   // Crossings into the link domain
   twm_sync u_lrst  (.clk_in(link_clk_in), .rst_b_in(1'h1), .d_in(rst_b_in), .q_out(lrst_b));
   twm_sync u_dis   (.clk_in(link_clk_in), .rst_b_in(lrst_b), .d_in(~master_enabled_out),
                     .q_out(dis_s));
   twm_sync u_start (.clk_in(link_clk_in), .rst_b_in(lrst_b), .d_in(start_tog_q),
                     .q_out(start_s));
   twm_sync u_ack   (.clk_in(link_clk_in), .rst_b_in(lrst_b), .d_in(ack_tog_q), .q_out(ack_s));
   twm_sync u_sda   (.clk_in(link_clk_in), .rst_b_in(lrst_b), .d_in(serial_data_line_in),
                     .q_out(sda_s));
   // Crossings into the system domain
   twm_sync u_idle  (.clk_in(clk_in), .rst_b_in(rst_b_in), .d_in(~idle_q), .q_out(busy_s));
   twm_sync u_need  (.clk_in(clk_in), .rst_b_in(rst_b_in), .d_in(need_tog_q), .q_out(need_s));
   twm_sync u_alert (.clk_in(clk_in), .rst_b_in(rst_b_in), .d_in(smbus_alert_input_in),
                     .q_out(alert_s));
   // Clock line is sampled for completeness; no stretching support
   twm_sync u_scl   (.clk_in(clk_in), .rst_b_in(rst_b_in), .d_in(serial_clock_line_in),
                     .q_out(scl_pin_s));

   // Enable state; disable strobe wins over enable
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         master_enabled_out <= 1'h0;
      end else if (master_disable_bit_in) begin
         master_enabled_out <= 1'h0;   // [RULE2]
      end else if (master_enable_in) begin
         master_enabled_out <= 1'h1;
      end
   end

   // Command capture; fields stay stable while the engine reads them
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         cmd_ready_out <= 1'h1;
         start_tog_q   <= 1'h0;
         addr_q        <= 7'h00;
         count_q       <= 8'h00;
         idle_d1_q     <= 1'h1;
      end else begin
         idle_d1_q <= idle_s;
         if (cmd_start_in && cmd_ready_out && master_enabled_out) begin
            cmd_ready_out <= 1'h0;
            start_tog_q   <= ~start_tog_q;
            addr_q        <= cmd_addr_in;
            count_q       <= cmd_count_in;
         end else if ((idle_s && !idle_d1_q) || !master_enabled_out) begin
            cmd_ready_out <= 1'h1;   // Engine back to idle, or aborted
         end
      end
   end

   // Idle flag and alert, registered copies of synced levels
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         idle_status_flag_out <= 1'h1;
         alert_out            <= 1'h0;
      end else begin
         idle_status_flag_out <= idle_s;
         alert_out            <= alert_s;   // High means alert [RULE5]
      end
   end

   // Byte request handshake; hold stays put until the engine takes it
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         need_seen_q    <= 1'h0;
         byte_ready_out <= 1'h0;
         ack_tog_q      <= 1'h0;
         hold_q         <= 8'h00;
      end else begin
         if (need_s != need_seen_q) begin
            need_seen_q    <= need_s;
            byte_ready_out <= 1'h1;
         end else if (byte_ready_out && byte_valid_in) begin
            byte_ready_out <= 1'h0;
            hold_q         <= byte_data_in;
            ack_tog_q      <= ~ack_tog_q;
         end
      end
   end

   // Pin drive values are always low; only the enables move
   always_ff @(posedge clk_in) begin
      serial_clock_line_out <= 1'h0;
      serial_data_line_out  <= 1'h0;
   end

   assign serial_clock_line_oe_out = scl_oe_q;
   assign serial_data_line_oe_out  = sda_oe_q;
   assign cnt_m1 = cnt_q - CNT_ONE;
   assign idle_s = ~busy_s;   // Busy crosses, so a synchroniser in reset reads as idle

   // Serial engine; disable overrides every state and frees both lines
   always_ff @(posedge link_clk_in) begin
      if (!lrst_b) begin
         state_q      <= ST_IDLE;
         scl_oe_q     <= 1'h0;
         sda_oe_q     <= 1'h0;
         idle_q       <= 1'h1;
         ph_q         <= PH_FIRST;
         bit_q        <= BIT_MSB;
         shift_q      <= 8'h00;
         cnt_q        <= 8'h00;
         start_seen_q <= 1'h0;
         ack_seen_q   <= 1'h0;
         need_tog_q   <= 1'h0;
         ack_kind_q   <= ACK_AFTER_ADDR;
      end else if (dis_s) begin
         state_q      <= ST_IDLE;   // STOP in flight is cut short [RULE3]
         scl_oe_q     <= 1'h0;      // [RULE3]
         sda_oe_q     <= 1'h0;      // [RULE3]
         idle_q       <= 1'h1;
         ph_q         <= PH_FIRST;
         start_seen_q <= start_s;
         ack_seen_q   <= ack_s;
      end else begin
         ph_q <= ph_q + 3'h1;
         case (state_q)
            ST_IDLE: begin
               ph_q     <= PH_FIRST;
               scl_oe_q <= 1'h0;
               sda_oe_q <= 1'h0;
               idle_q   <= 1'h1;
               if (start_s != start_seen_q) begin
                  start_seen_q <= start_s;
                  shift_q      <= {addr_q, RW_WRITE};
                  cnt_q        <= count_q;
                  idle_q       <= 1'h0;
                  state_q      <= ST_START;
               end
            end
            ST_START: begin
               if (ph_q == PH_SDA_MID) begin
                  sda_oe_q <= 1'h1;   // Data falls while clock high
               end
               if (ph_q == PH_LAST) begin
                  scl_oe_q   <= 1'h1;
                  bit_q      <= BIT_MSB;
                  ack_kind_q <= ACK_AFTER_ADDR;
                  state_q    <= ST_ADDR;
               end
            end
            ST_ADDR, ST_DATA: begin
               if (ph_q == PH_FIRST) begin
                  sda_oe_q <= ~shift_q[7];
               end
               scl_oe_q <= (ph_q < PH_SCL_UP) || (ph_q >= PH_SCL_DN);
               if (ph_q == PH_LAST) begin
                  shift_q <= {shift_q[6:0], 1'h0};
                  bit_q   <= bit_q - 3'h1;
                  if (bit_q == BIT_LSB) begin
                     state_q <= ST_AACK;
                  end
               end
            end
            ST_AACK: begin
               if (ph_q == PH_FIRST) begin
                  sda_oe_q <= 1'h0;   // Let the slave answer
               end
               scl_oe_q <= (ph_q < PH_SCL_UP) || (ph_q >= PH_SCL_DN);
               if (ph_q == PH_LAST) begin
                  if (ack_kind_q == ACK_AFTER_DATA) begin
                     cnt_q <= cnt_m1;
                  end
                  if (sda_s) begin
                     // NAK: flag idle now if bytes remain, still send STOP
                     if ((ack_kind_q == ACK_AFTER_ADDR && cnt_q != CNT_NONE) ||
                         (ack_kind_q == ACK_AFTER_DATA && cnt_m1 != CNT_NONE)) begin
                        idle_q <= 1'h1;   // [RULE1]
                     end
                     state_q <= ST_STOP;   // [RULE7]
                  end else if ((ack_kind_q == ACK_AFTER_ADDR && cnt_q == CNT_NONE) ||
                               (ack_kind_q == ACK_AFTER_DATA && cnt_m1 == CNT_NONE)) begin
                     state_q <= ST_STOP;
                  end else begin
                     need_tog_q <= ~need_tog_q;
                     state_q    <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               // Clock held low while software supplies the byte
               ph_q     <= PH_FIRST;
               scl_oe_q <= 1'h1;
               if (ack_s != ack_seen_q) begin
                  ack_seen_q <= ack_s;
                  shift_q    <= hold_q;
                  bit_q      <= BIT_MSB;
                  ack_kind_q <= ACK_AFTER_DATA;
                  state_q    <= ST_DATA;
               end
            end
            ST_STOP: begin
               if (ph_q == PH_FIRST) begin
                  sda_oe_q <= 1'h1;
                  scl_oe_q <= 1'h1;
               end
               if (ph_q == PH_SCL_UP) begin
                  scl_oe_q <= 1'h0;
               end
               if (ph_q == PH_STOP_UP) begin
                  sda_oe_q <= 1'h0;   // Data rises while clock high
               end
               if (ph_q == PH_LAST) begin
                  idle_q  <= 1'h1;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Checks on the link engine and on the system-domain enable and alert logic
   sequence nak_left_s;
      state_q == ST_AACK && ph_q == PH_LAST && sda_s && !dis_s &&
      ((ack_kind_q == ACK_AFTER_ADDR && cnt_q != CNT_NONE) ||
       (ack_kind_q == ACK_AFTER_DATA && cnt_m1 != CNT_NONE));
   endsequence

   idle_on_nak_a: assert property (@(posedge link_clk_in) disable iff (!lrst_b) // [RULE1]
      nak_left_s |=> idle_q && state_q == ST_STOP)
      else $error("idle flag not raised on NAK with bytes left");

   stop_after_nak_a: assert property (@(posedge link_clk_in) disable iff (!lrst_b) // [RULE7]
      nak_left_s ##1 !dis_s [*8] |=> state_q == ST_IDLE && !sda_oe_q && !scl_oe_q)
      else $error("STOP not completed after NAK");

   disable_bit_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE2]
      master_disable_bit_in |=> !master_enabled_out ##1 cmd_ready_out)
      else $error("master not disabled by disable bit");

   lines_release_a: assert property (@(posedge link_clk_in) disable iff (!lrst_b) // [RULE3]
      dis_s |=> !scl_oe_q && !sda_oe_q && idle_q && state_q == ST_IDLE)
      else $error("lines not released on disable");

   alert_polarity_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE5]
      $rose(smbus_alert_input_in) ##1 smbus_alert_input_in [*2] |=> alert_out)
      else $error("alert input not treated as active high");

endmodule

/* File: logic/twm_pkg.sv */
// Constants shared by the two-wire master engine and its testbench
package twm_pkg;

   // Serial bit timing, counted in link clock ticks per bit
   localparam int unsigned PH_W       = 3;
   localparam logic [2:0]  PH_FIRST   = 3'h0;
   localparam logic [2:0]  PH_SCL_UP  = 3'h2;   // Clock line released here
   localparam logic [2:0]  PH_SDA_MID = 3'h3;   // Start edge on the data line
   localparam logic [2:0]  PH_SCL_DN  = 3'h6;   // Clock line pulled low again
   localparam logic [2:0]  PH_STOP_UP = 3'h5;   // Stop edge on the data line
   localparam logic [2:0]  PH_LAST    = 3'h7;

   // Byte framing
   localparam logic [2:0]  BIT_MSB    = 3'h7;
   localparam logic [2:0]  BIT_LSB    = 3'h0;
   localparam logic        RW_WRITE   = 1'h0;
   localparam logic [7:0]  CNT_NONE   = 8'h00;
   localparam logic [7:0]  CNT_ONE    = 8'h01;

   // Serial engine states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_START = 7'h02,
      ST_ADDR  = 7'h04,
      ST_AACK  = 7'h08,
      ST_WAIT  = 7'h10,
      ST_DATA  = 7'h20,
      ST_STOP  = 7'h40
   } twm_state_e;

   // Acknowledge slot after a data byte reuses the address ack state logic
   localparam logic ACK_AFTER_ADDR = 1'h0;
   localparam logic ACK_AFTER_DATA = 1'h1;

endpackage

/* File: logic/twm_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module twm_sync (
   // Clock and reset of the receiving domain
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   // Level from the other domain and its safe copy
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         meta_q <= 1'h0;
         q_out  <= 1'h0;
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule

/* File: testbench/test_two_wire_master_idle_disable.sv */
// Self-checking bench for the two-wire master idle flag, disable and alert
`timescale 1ns/1ps
module test_two_wire_master_idle_disable import twm_pkg::*;;
   logic       clk_in, rst_b_in, link_clk_in, en, dis, start, bv, alert_in, nak;
   logic [6:0] addr;
   logic [7:0] cnt, bd, rx_b, rx_c, stop_c, seen, s0, e;
   wire        enabled, rdy, idle, brdy, scl_oe, sda_oe, alert_o, s_oe, scl_o, sda_o;
   wire        scl = ~scl_oe;
   wire        sda = ~(sda_oe | s_oe);
   int         err_total, checks;
   logic [7:0] exp_q[$];

   twm_master twm_master_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk_in),
      .master_enable_in(en), .master_disable_bit_in(dis), .master_enabled_out(enabled),
      .cmd_start_in(start), .cmd_addr_in(addr), .cmd_count_in(cnt), .cmd_ready_out(rdy),
      .idle_status_flag_out(idle), .byte_valid_in(bv), .byte_data_in(bd),
      .byte_ready_out(brdy), .serial_clock_line_in(scl), .serial_clock_line_out(scl_o),
      .serial_clock_line_oe_out(scl_oe), .serial_data_line_in(sda),
      .serial_data_line_out(sda_o), .serial_data_line_oe_out(sda_oe),
      .smbus_alert_input_in(alert_in), .alert_out(alert_o));

   twm_slave_model twm_slave_model_i (.scl_in(scl), .sda_in(sda), .nak_in(nak),
      .sda_oe_out(s_oe), .rx_byte_out(rx_b), .rx_cnt_out(rx_c), .stop_cnt_out(stop_c));

   // Link clock offset so its edges never meet the system clock edges
   initial begin clk_in = 1'b0; forever #12.5 clk_in = ~clk_in; end
   initial begin link_clk_in = 1'b0; #7; forever #80 link_clk_in = ~link_clk_in; end

   task chk(input logic c, input string m);
      checks++;
      if (c !== 1'b1) begin
         err_total++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task end_sim;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Idle must first drop, then come back within one long transfer
   task wait_idle;
      int i;
      for (i = 0; i < 60 && idle === 1'b1; i++) @(posedge clk_in);
      chk(idle === 1'b0, "idle flag never fell");
      for (i = 0; i < 4000 && idle !== 1'b1; i++) @(posedge clk_in);
      chk(idle === 1'b1, "idle flag never rose");
   endtask

   task xfer(input logic n_in, input logic [7:0] c_in);
      logic [6:0] a;
      a = 7'($urandom);
      nak <= n_in;
      addr <= a;
      cnt <= c_in;
      start <= 1'b1;
      exp_q.push_back({a, RW_WRITE});
      s0 = stop_c;
      @(posedge clk_in);
      start <= 1'b0;
      wait_idle();
   endtask

   // Disable pulse, then both lines must be let go within a few link ticks
   task off;
      dis <= 1'b1;
      @(posedge clk_in);
      dis <= 1'b0;
      repeat (28) @(posedge clk_in);
      chk(enabled === 1'b0 && scl_oe === 1'b0 && sda_oe === 1'b0, "master still on bus");
      chk(scl === 1'b1 && sda === 1'b1, "lines not high after disable");
      chk(scl_o === 1'b0 && sda_o === 1'b0, "pin drive value not low");
   endtask

   task enable;
      en <= 1'b1;
      @(posedge clk_in);
      en <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask

   // Byte source: valid held until the edge that takes it
   always @(posedge clk_in) begin
      if (bv && brdy) bv <= 1'b0;
      else if (brdy && !bv) begin
         e = 8'($urandom);
         bd <= e;
         bv <= 1'b1;
         exp_q.push_back(e);
      end
   end

   // Each byte seen by the slave is matched against the oldest note
   always @(posedge clk_in) begin
      if (rx_c !== seen) begin
         seen <= rx_c;
         if (exp_q.size() == 0) chk(1'b0, "unexpected byte on bus");
         else chk(rx_b === exp_q.pop_front(), "wrong byte on bus");
      end
   end

   initial begin
      #600000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim();
   end

   initial begin
      {rst_b_in, en, dis, start, bv, alert_in, nak} = 7'h00;
      addr = 7'h00;
      {cnt, bd, seen} = 24'h0000_00;
      err_total = 0;
      checks = 0;
      void'($urandom(96020));
      // Reset spans four link edges too, the link side syncs it in
      repeat (6) @(posedge clk_in);
      repeat (4) @(posedge link_clk_in);
      @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      chk(idle === 1'b1 && rdy === 1'b1 && enabled === 1'b0 && alert_o === 1'b0, "reset");
      $display("test reset done");
      en <= 1'b1;
      dis <= 1'b1;
      repeat (2) @(posedge clk_in);
      chk(enabled === 1'b0, "enable won over disable");
      dis <= 1'b0;
      @(posedge clk_in);
      en <= 1'b0;
      repeat (2) @(posedge clk_in);
      chk(enabled === 1'b1, "enable ignored");
      $display("test enable done");
      xfer(1'b0, 8'h01);
      chk(stop_c !== s0, "idle before stop on acked write");
      repeat (6) @(posedge clk_in);
      xfer(1'b1, 8'h02);
      chk(stop_c === s0, "idle waited for stop after nak");
      repeat (200) @(posedge clk_in);
      chk(stop_c !== s0 && enabled === 1'b1, "no stop after nak");
      $display("test nak done");
      xfer(1'b1, 8'h02);
      off();
      $display("test cut stop done");
      enable();
      xfer(1'b0, 8'h02);
      repeat (103) @(posedge clk_in); // Two serial periods before disable
      off();
      $display("test late disable done");
      alert_in <= 1'b1; // Alert pin not shared with a slave unit
      repeat (4) @(posedge clk_in);
      chk(alert_o === 1'b1, "high alert not seen");
      alert_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      chk(alert_o === 1'b0, "low alert seen as active");
      $display("test alert done");
      chk(exp_q.size() == 0, "bytes never reached slave");
      end_sim();
   end
endmodule

/* File: testbench/twm_slave_model.sv */
// Behavioural write-only slave device on the two-wire bus
`timescale 1ns/1ps
module twm_slave_model (
   // Bus wires as seen behind the pull-ups
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   // Refuse every byte with a NAK
   input  wire logic       nak_in,
   // Data line pull-down and received traffic
   output logic            sda_oe_out,
   output logic [7:0]      rx_byte_out,
   output logic [7:0]      rx_cnt_out,
   output logic [7:0]      stop_cnt_out
);
   logic [3:0] bit_q;

   initial begin
      sda_oe_out = 1'b0;
      rx_byte_out = 8'h00;
      rx_cnt_out = 8'h00;
      stop_cnt_out = 8'h00;
      bit_q = 4'h0;
   end

   // Start restarts the bit count; stop is only counted, never trusted
   always @(negedge sda_in) if (scl_in) bit_q = 4'h0;
   always @(posedge sda_in) if (scl_in) stop_cnt_out++;

   // Shift on the clock rise, ninth rise is the ack slot
   always @(posedge scl_in) begin
      if (bit_q < 4'h8) rx_byte_out = {rx_byte_out[6:0], sda_in};
      bit_q++;
      if (bit_q == 4'h8) rx_cnt_out++;
   end

   // Ack driven while the clock is low so the data never moves under a high clock
   always @(negedge scl_in) begin
      if (bit_q == 4'h8) sda_oe_out = !nak_in;
      else if (bit_q == 4'h9) begin
         sda_oe_out = 1'b0;
         bit_q = 4'h0;
      end
   end
endmodule
